// ===== core/tsw_switch_core.sv
// switch core: host port, control register, memories and link service
`timescale 1ns/10ps
`default_nettype none
`include "tsw_defines.svh"
module tsw_switch_core
    import tsw_pkg::*;
#(
    parameter int NSTREAM = 4,
    parameter int NCH     = 32
) (
    input  wire logic       i_mclk,
    input  wire logic       i_resetn,
    input  wire logic       i_clk_en,
    input  wire logic       i_link_clk,
    input  wire logic       i_frame_n,
    input  wire logic       i_output_drive_gate,
    input  wire logic [3:0] i_serial_in_lanes,
    input  wire logic       i_cs_n,
    input  wire logic       i_host_strobe,
    input  wire logic       i_rw,
    input  wire logic [5:0] i_addr,
    input  wire logic [7:0] i_data,
    output logic      [7:0] o_data,
    output logic            o_data_oe,
    output logic            o_access_acknowledge_n,
    output logic            o_access_acknowledge_n_oe,
    output logic      [3:0] o_serial_out_lanes,
    output logic      [3:0] o_serial_out_lanes_oe
);
    // ****************************************************************
    // elaboration check
    // ****************************************************************

    // the control register has two stream bits and the address five channel bits
    if (NSTREAM != 4 || NCH != 32) begin : g_bad_size
        $error("tsw_switch_core serves four streams of 32 channels only");
    end

    // ****************************************************************
    // declarations
    // ****************************************************************

    tsw_xing_if x ();

    tsw_host_type host_reg;
    tsw_host_type host_next;

    // memories indexed {stream, channel}
    logic [7:0] dm_mem  [0:127];
    logic [7:0] cml_mem [0:127];
    logic [7:0] cmh_mem [0:127];

    logic        cs_n;
    logic        strobe;
    logic        rw;
    logic [5:0]  addr;
    logic [7:0]  din;
    logic        access;
    logic        host_go;
    logic        host_wr;
    logic [6:0]  host_idx;
    logic [1:0]  rd_sel;
    logic [1:0]  wr_sel;
    logic [7:0]  rd_val;
    logic        cml_we;
    logic        cmh_we;
    logic        link_ev;
    logic [31:0] src_w;
    logic [31:0] attr_w;
    logic [31:0] dmv_w;
    logic [31:0] tx_b_w;
    logic [3:0]  tx_e_w;

    // ****************************************************************
    // link engine
    // ****************************************************************

    tsw_link u_link (
        .i_link_clk            (i_link_clk),
        .i_resetn              (i_resetn),
        .i_clk_en              (i_clk_en),
        .i_frame_n             (i_frame_n),
        .i_output_drive_gate   (i_output_drive_gate),
        .i_serial_in_lanes     (i_serial_in_lanes),
        .x                     (x.link),
        .o_serial_out_lanes    (o_serial_out_lanes),
        .o_serial_out_lanes_oe (o_serial_out_lanes_oe)
    );

    // ****************************************************************
    // host port decode
    // ****************************************************************

    // pins are read only after the second sync stage
    assign cs_n = host_reg.bus_s2[16];
    assign strobe = host_reg.bus_s2[15];
    assign rw = host_reg.bus_s2[14];
    assign addr = host_reg.bus_s2[13:8];
    assign din = host_reg.bus_s2[7:0];
    assign access = !cs_n && strobe;
    assign host_go = i_clk_en && host_reg.st == TSW_IDLE && access;
    assign host_wr = host_go && !rw && addr[`TSW_A_TOP];
    assign host_idx = {host_reg.ctrl[`TSW_CR_STR], addr[4:0]};

    // split mode forces the read and write targets apart
    always_comb begin
        if (host_reg.ctrl[`TSW_CR_SPLIT]) begin
            rd_sel = `TSW_SEL_DATA;
            wr_sel = `TSW_SEL_CML;
        end else begin
            rd_sel = host_reg.ctrl[`TSW_CR_SEL];
            wr_sel = host_reg.ctrl[`TSW_CR_SEL];
        end
    end

    // read data; the test page answers zero since it has no storage here
    always_comb begin
        if (!addr[`TSW_A_TOP]) begin
            rd_val = host_reg.ctrl;
        end else begin
            case (rd_sel)
                `TSW_SEL_DATA: rd_val = dm_mem[host_idx];
                `TSW_SEL_CML: rd_val = cml_mem[host_idx];
                `TSW_SEL_CMH: rd_val = cmh_mem[host_idx];
                default: rd_val = 8'h00;
            endcase
        end
    end

    assign cml_we = host_wr && wr_sel == `TSW_SEL_CML;
    assign cmh_we = host_wr && wr_sel == `TSW_SEL_CMH;
    assign link_ev = i_clk_en && host_reg.req_s2 != host_reg.req_seen;

    // ****************************************************************
    // output channel sourcing
    // ****************************************************************

    // one lookup per stream for the channel the link asked for
    always_comb begin
        for (int s = 0; s < 4; s++) begin
            src_w[s*8 +: 8] = cml_mem[{2'(s), x.req_ch}];
            attr_w[s*8 +: 8] = cmh_mem[{2'(s), x.req_ch}];
            // bits 6-5 stream, 4-0 channel, matching the memory index
            dmv_w[s*8 +: 8] = dm_mem[src_w[s*8 +: 7]];
            if (host_reg.ctrl[`TSW_CR_MSG] || attr_w[s*8 + `TSW_CMH_MSG]) begin
                tx_b_w[s*8 +: 8] = src_w[s*8 +: 8];
            end else begin
                tx_b_w[s*8 +: 8] = dmv_w[s*8 +: 8];
            end
            tx_e_w[s] = host_reg.ctrl[`TSW_CR_MSG] || attr_w[s*8 + `TSW_CMH_OE];
        end
    end

    // ****************************************************************
    // state update
    // ****************************************************************

    // a low clock enable freezes every field, syncs included
    always_comb begin
        host_next = host_reg;
        if (i_clk_en) begin
            host_next.bus_s1 = {i_cs_n, i_host_strobe, i_rw, i_addr, i_data};
            host_next.bus_s2 = host_reg.bus_s1;
            host_next.req_s1 = x.req_tog;
            host_next.req_s2 = host_reg.req_s1;
            case (host_reg.st)
                TSW_IDLE: begin
                    if (access) begin
                        if (!rw && !addr[`TSW_A_TOP]) begin
                            host_next.ctrl = din;
                        end
                        host_next.rdata = rd_val;
                        host_next.data_oe = rw;
                        host_next.ack_oe = 1'b1;
                        host_next.st = TSW_HOLD;
                    end
                end
                TSW_HOLD: begin
                    // hold the answer until select or strobe lets go
                    if (!access) begin
                        host_next.data_oe = 1'b0;
                        host_next.ack_oe = 1'b0;
                        host_next.st = TSW_IDLE;
                    end
                end
                default: host_next.st = TSW_IDLE;
            endcase
            // reply to the link: new bytes and the toggle in the same cycle
            if (link_ev) begin
                host_next.req_seen = host_reg.req_s2;
                host_next.tx_bytes = tx_b_w;
                host_next.tx_en = tx_e_w;
                host_next.ack_tog = ~host_reg.ack_tog;
            end
        end
    end

    // reset leaves the control register at zero: normal, test page
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            host_reg <= '0;
        end else begin
            host_reg <= host_next;
        end
    end

    // memories carry no reset; host must program connections first
    always_ff @(posedge i_mclk) begin
        if (link_ev) begin
            for (int s = 0; s < 4; s++) begin
                dm_mem[{2'(s), x.rx_ch}] <= x.rx_bytes[s*8 +: 8];
            end
        end
        if (cml_we) begin
            cml_mem[host_idx] <= din;
        end
        if (cmh_we) begin
            cmh_mem[host_idx] <= din;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************

    assign o_data = host_reg.rdata;
    assign o_data_oe = host_reg.data_oe;
    assign o_access_acknowledge_n = host_reg.ack_n; // open drain, always low when enabled
    assign o_access_acknowledge_n_oe = host_reg.ack_oe;
    assign x.ack_tog = host_reg.ack_tog;
    assign x.tx_bytes = host_reg.tx_bytes;
    assign x.tx_en = host_reg.tx_en;

    // ****************************************************************
    // assertions
    // ****************************************************************

    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (!i_resetn);

    a_ctrl_write: assert property (
        host_go && !rw && !addr[`TSW_A_TOP] |=> host_reg.ctrl == $past(din))
        else $error("control write with top address low was lost");
    a_ctrl_read: assert property (
        host_go && rw && !addr[`TSW_A_TOP] |=> o_data_oe && o_data == $past(host_reg.ctrl))
        else $error("control read did not return the register");
    a_split_write: assert property (
        host_wr && host_reg.ctrl[`TSW_CR_SPLIT] |-> cml_we && !cmh_we)
        else $error("split mode write missed the low connection memory");
    a_split_read: assert property (
        host_go && rw && addr[`TSW_A_TOP] && host_reg.ctrl[`TSW_CR_SPLIT]
        |=> o_data == $past(dm_mem[host_idx]))
        else $error("split mode read not from data memory");
    a_test_page: assert property (
        host_wr && !host_reg.ctrl[`TSW_CR_SPLIT] && host_reg.ctrl[`TSW_CR_SEL] == `TSW_SEL_TEST
        |-> !cml_we && !cmh_we)
        else $error("test page write reached a connection memory");
    a_high_page: assert property (
        host_wr && !host_reg.ctrl[`TSW_CR_SPLIT]
        |-> cmh_we == (host_reg.ctrl[`TSW_CR_SEL] == `TSW_SEL_CMH))
        else $error("high connection write does not follow the select bits");
    a_ack_cycle: assert property (
        host_go |=> o_access_acknowledge_n_oe && !o_access_acknowledge_n)
        else $error("acknowledge not pulled after access");
    a_ack_release: assert property (
        i_clk_en && host_reg.st == TSW_HOLD && !access
        |=> !o_access_acknowledge_n_oe && !o_data_oe ##1 host_reg.st == TSW_IDLE)
        else $error("acknowledge or data held after strobe release");
    a_global_msg: assert property (
        link_ev && host_reg.ctrl[`TSW_CR_MSG]
        |=> host_reg.tx_en == 4'hF && host_reg.tx_bytes == $past(src_w))
        else $error("global message mode did not send every low connection byte");
    a_chan_msg: assert property (
        link_ev && attr_w[`TSW_CMH_MSG] |=> host_reg.tx_bytes[7:0] == $past(src_w[7:0]))
        else $error("message channel did not send its low connection byte");
    a_switched: assert property (
        link_ev && !host_reg.ctrl[`TSW_CR_MSG] && !attr_w[`TSW_CMH_MSG]
        |=> host_reg.tx_bytes[7:0] == $past(dmv_w[7:0]))
        else $error("switched channel did not send the addressed input byte");
    a_chan_enable: assert property (
        link_ev && !host_reg.ctrl[`TSW_CR_MSG] |=> host_reg.tx_en[0] == $past(attr_w[0]))
        else $error("channel driver does not follow its enable bit");
    a_reply_toggle: assert property (
        link_ev |=> host_reg.ack_tog != $past(host_reg.ack_tog) ##1 !link_ev)
        else $error("link request not answered once");

    c_split_write: cover property (host_wr && host_reg.ctrl[`TSW_CR_SPLIT]);
    c_ctrl_read: cover property (host_go && rw && !addr[`TSW_A_TOP] ##[1:20] !access);
    c_global_msg: cover property (link_ev && host_reg.ctrl[`TSW_CR_MSG]);
    c_float_chan: cover property (link_ev && !host_reg.ctrl[`TSW_CR_MSG] && !attr_w[0]);
endmodule
`default_nettype wire

// ===== core/tsw_defines.svh
// offsets, field positions, codes and timing counts of the tdm switch
// Notes on behaviour
// - top address low always reaches control register
// - top address high: low five bits pick channel
// - split bit: reads data memory, writes low connection
// - select bits pick test, data, low, high memory
// - stream bits pick the memory subsection
// - global message bit sends low connection everywhere
// - per-channel message bit sends low connection byte
// - otherwise send switched input byte named by entry
// - entry bits six-five give source stream
// - entry bits four-zero give source channel
// - drive gate low floats every serial output
// - gate high and global message drive everything
// - otherwise high entry bit zero enables channel
// - message byte repeats each frame until rewritten
// - each input lane carries 32 stored channels
// - control register is readable and writable
`ifndef TSW_DEFINES_SVH
`define TSW_DEFINES_SVH
`define TSW_A_TOP    5
`define TSW_CR_SPLIT 7
`define TSW_CR_MSG   6
`define TSW_CR_SEL   4:3
`define TSW_CR_STR   1:0
`define TSW_CR_RESET 8'h00
`define TSW_CMH_MSG  2
`define TSW_CMH_OE   0
`define TSW_SEL_TEST 2'h0
`define TSW_SEL_DATA 2'h1
`define TSW_SEL_CML  2'h2
`define TSW_SEL_CMH  2'h3
`define TSW_CH_END   4'hF
`define TSW_REQ_LEAD 5'h02
`endif

// ===== core/tsw_pkg.sv
// state types of the switch core and its link engine
package tsw_pkg;
    typedef enum logic [0:0] {TSW_IDLE, TSW_HOLD} tsw_host_st_type;
    typedef struct packed {
        logic [16:0]     bus_s1;
        logic [16:0]     bus_s2;
        logic            req_s1;
        logic            req_s2;
        logic            req_seen;
        logic [7:0]      ctrl;
        tsw_host_st_type st;
        logic [7:0]      rdata;
        logic            data_oe;
        logic            ack_oe;
        logic            ack_n;
        logic            ack_tog;
        logic [31:0]     tx_bytes;
        logic [3:0]      tx_en;
    } tsw_host_type;
    typedef struct packed {
        logic        fr_s1;
        logic        fr_s2;
        logic        gate_s1;
        logic        gate_s2;
        logic        ce_s1;
        logic        ce_s2;
        logic [3:0]  in_s1;
        logic [3:0]  in_s2;
        logic        ack_s1;
        logic        ack_s2;
        logic        ack_seen;
        logic [8:0]  cnt;
        logic [31:0] rx_sh;
        logic [31:0] rx_hold;
        logic [4:0]  rx_ch;
        logic [4:0]  req_ch;
        logic        req_tog;
        logic [31:0] tx_buf;
        logic [3:0]  en_buf;
        logic [31:0] tx_sh;
        logic [3:0]  en_cur;
        logic [3:0]  out;
        logic [3:0]  out_oe;
    } tsw_link_type;
endpackage

// ===== core/tsw_xing_if.sv
// crossing between the link engine and the switch core
`timescale 1ns/10ps
`default_nettype none
interface tsw_xing_if;
    logic        req_tog;
    logic [4:0]  req_ch;
    logic [4:0]  rx_ch;
    logic [31:0] rx_bytes;
    logic        ack_tog;
    logic [31:0] tx_bytes;
    logic [3:0]  tx_en;
    modport link (output req_tog, req_ch, rx_ch, rx_bytes, input ack_tog, tx_bytes, tx_en);
    modport core (input req_tog, req_ch, rx_ch, rx_bytes, output ack_tog, tx_bytes, tx_en);
endinterface
`default_nettype wire

// ===== core/tsw_link.sv
// link engine: frame count, lane shifters and per-channel handshake
`timescale 1ns/10ps
`default_nettype none
`include "tsw_defines.svh"
module tsw_link
    import tsw_pkg::*;
(
    input  wire logic       i_link_clk,
    input  wire logic       i_resetn,
    input  wire logic       i_clk_en,
    input  wire logic       i_frame_n,
    input  wire logic       i_output_drive_gate,
    input  wire logic [3:0] i_serial_in_lanes,
    tsw_xing_if.link        x,
    output logic      [3:0] o_serial_out_lanes,
    output logic      [3:0] o_serial_out_lanes_oe
);
    tsw_link_type link_reg;
    tsw_link_type link_next;

    // cnt = {channel, bit, half}; the frame pulse zeroes it, so 32 channels fit a frame
    always_comb begin
        link_next = link_reg;
        link_next.fr_s1 = i_frame_n;
        link_next.fr_s2 = link_reg.fr_s1;
        link_next.gate_s1 = i_output_drive_gate;
        link_next.gate_s2 = link_reg.gate_s1;
        link_next.ce_s1 = i_clk_en;
        link_next.ce_s2 = link_reg.ce_s1;
        link_next.ack_s1 = x.ack_tog;
        link_next.ack_s2 = link_reg.ack_s1;
        link_next.in_s1 = i_serial_in_lanes;
        link_next.in_s2 = link_reg.in_s1;
        // the gate overrides everything, even while frozen
        link_next.out_oe = link_reg.en_cur & {4{link_reg.gate_s2}};
        if (link_reg.ce_s2) begin
            link_next.cnt = link_reg.fr_s2 ? link_reg.cnt + 9'h001 : 9'h000;
            if (link_reg.ack_s2 != link_reg.ack_seen) begin
                link_next.ack_seen = link_reg.ack_s2;
                link_next.tx_buf = x.tx_bytes;
                link_next.en_buf = x.tx_en;
            end
            for (int s = 0; s < 4; s++) begin
                if (link_reg.cnt[0]) begin
                    link_next.rx_sh[s*8 +: 8] = {link_reg.rx_sh[s*8 +: 7], link_reg.in_s2[s]};
                end
                link_next.out[s] = link_reg.tx_sh[s*8 + 7 - int'(link_reg.cnt[3:1])];
            end
            // channel end: hand the received bytes over, ask two channels ahead
            if (link_reg.cnt[3:0] == `TSW_CH_END) begin
                link_next.rx_hold = link_next.rx_sh;
                link_next.rx_ch = link_reg.cnt[8:4];
                link_next.req_ch = link_reg.cnt[8:4] + `TSW_REQ_LEAD;
                link_next.req_tog = ~link_reg.req_tog;
                link_next.tx_sh = link_reg.tx_buf;
                link_next.en_cur = link_reg.en_buf;
            end
        end
    end

    always_ff @(posedge i_link_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            link_reg <= '0;
        end else begin
            link_reg <= link_next;
        end
    end

    assign x.req_tog = link_reg.req_tog;
    assign x.req_ch = link_reg.req_ch;
    assign x.rx_ch = link_reg.rx_ch;
    assign x.rx_bytes = link_reg.rx_hold;
    assign o_serial_out_lanes = link_reg.out;
    assign o_serial_out_lanes_oe = link_reg.out_oe;

    a_gate_floats: assert property (@(posedge i_link_clk) disable iff (!i_resetn)
        !link_reg.gate_s2 |=> link_reg.out_oe == 4'h0)
        else $error("serial output driven while drive gate low");
    a_frame_zero: assert property (@(posedge i_link_clk) disable iff (!i_resetn)
        link_reg.ce_s2 && !link_reg.fr_s2 |=> link_reg.cnt == 9'h000)
        else $error("frame pulse did not restart the channel count");
    c_frame_wrap: cover property (@(posedge i_link_clk) disable iff (!i_resetn)
        link_reg.cnt == 9'h1FF ##1 link_reg.cnt == 9'h000);
endmodule
`default_nettype wire

// ===== sim/tsw_lane_feed.sv
// far-side lane feeder: frame pulse and serial input lanes
`timescale 1ns/10ps
`default_nettype none
module tsw_lane_feed (
    input  wire logic       i_link_clk,
    input  wire logic       i_resetn,
    output logic            o_frame_n,
    output logic      [3:0] o_serial_in_lanes
);
    logic [8:0] cnt_reg;

    // ************************************************
    // frame of 32 channels, 16 link edges each
    // ************************************************
    // lanes 2 and 3 carry all-ones and all-zeros bytes so switched data is
    // independent of bit alignment; lanes 0 and 1 toggle so they are never constant
    always_ff @(posedge i_link_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            cnt_reg           <= 9'h000;
            o_frame_n         <= 1'b1;
            o_serial_in_lanes <= 4'h0;
        end else begin
            cnt_reg           <= cnt_reg + 9'h001;
            o_frame_n         <= (cnt_reg != 9'h1FF);
            o_serial_in_lanes <= {1'b0, 1'b1, cnt_reg[1], ~cnt_reg[1]};
        end
    end
endmodule
`default_nettype wire

// ===== sim/testbench.sv
// self-checking bench of the tdm switch core
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic            i_mclk     = 1'b0;
    logic            link_clk   = 1'b0;
    logic            i_resetn   = 1'b0;
    logic            cs_n       = 1'b1;
    logic            strobe     = 1'b0;
    logic            rw         = 1'b1;
    logic            gate       = 1'b1;
    logic            drv        = 1'b0;
    logic            ce         = 1'b1;
    logic            ack_q      = 1'b1;
    logic [5:0]      addr       = 6'h00;
    logic [5:0]      a;
    logic [7:0]      host_d     = 8'h00;
    logic [7:0]      v;
    logic [7:0]      exp_q[$];
    int              seed;
    int              checked    = 0;
    int              n_mismatch = 0;
    wire logic       frame_n;
    wire logic [3:0] lanes_in;
    wire logic [3:0] lanes;
    wire logic [3:0] lanes_oe;
    wire logic [7:0] rd;
    wire logic       rd_oe;
    wire logic       ack_v;
    wire logic       ack_oe;
    // data pins: device, else host, else the inverse of the last host byte
    wire logic [7:0] bus_d = rd_oe ? rd : (drv ? host_d : ~host_d);
    // acknowledge is open drain with a pull-up
    wire logic       ack_n = ack_oe ? ack_v : 1'b1;

    // ************************************************
    // clocks and instances
    // ************************************************
    always #5 i_mclk = ~i_mclk;
    always #24 link_clk = ~link_clk;

    tsw_lane_feed u_tsw_lane_feed (
        .i_link_clk(link_clk), .i_resetn(i_resetn),
        .o_frame_n(frame_n), .o_serial_in_lanes(lanes_in)
    );
    tsw_switch_core u_tsw_switch_core (
        .i_mclk(i_mclk), .i_resetn(i_resetn), .i_clk_en(ce), .i_link_clk(link_clk),
        .i_frame_n(frame_n), .i_output_drive_gate(gate), .i_serial_in_lanes(lanes_in),
        .i_cs_n(cs_n), .i_host_strobe(strobe), .i_rw(rw), .i_addr(addr), .i_data(bus_d),
        .o_data(rd), .o_data_oe(rd_oe), .o_access_acknowledge_n(ack_v),
        .o_access_acknowledge_n_oe(ack_oe), .o_serial_out_lanes(lanes),
        .o_serial_out_lanes_oe(lanes_oe)
    );

    // ************************************************
    // tasks
    // ************************************************
    task automatic close_out();
        $display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] e);
        checked++;
        if (got !== e) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, e);
        end
    endtask

    // bounded wait for the acknowledge pin to reach a level
    task automatic wait_ack(input logic lvl);
        int n;
        n = 0;
        while (ack_n !== lvl) begin
            @(negedge i_mclk);
            n++;
            if (n > 30) begin
                chk({7'h00, ack_n}, {7'h00, lvl});
                close_out();
            end
        end
    endtask

    // one host access; a read notes its expected byte for the monitor
    task automatic acc(input logic r, input logic [5:0] ad, input logic [7:0] d,
                       input logic [7:0] e);
        @(posedge i_mclk);
        cs_n   <= 1'b0;
        strobe <= 1'b1;
        rw     <= r;
        addr   <= ad;
        host_d <= d;
        drv    <= ~r;
        if (r) exp_q.push_back(e);
        wait_ack(1'b0);
        @(posedge i_mclk);
        cs_n   <= 1'b1;
        strobe <= 1'b0;
        drv    <= 1'b0;
        wait_ack(1'b1);
    endtask

    // select a page, then write all 32 channels of it
    task automatic fill(input logic [7:0] c, input logic [7:0] b, input logic per_ch);
        acc(1'b0, 6'h00, c, 8'h00);
        for (int ch = 0; ch < 32; ch++) acc(1'b0, {1'b1, 5'(ch)}, per_ch ? b | 8'(ch) : b, 8'h00);
    endtask

    // settle two frames, then keep the first deviating sample of 64
    task automatic lanes_chk(input logic [3:0] m, input logic [3:0] ev, input logic [3:0] eoe);
        logic [7:0] got;
        repeat (1100) @(posedge link_clk);
        got = {ev & m, eoe};
        repeat (64) begin
            @(negedge link_clk);
            if (got === {ev & m, eoe}) got = {lanes & m, lanes_oe};
        end
        chk(got, {ev & m, eoe});
    endtask

    // each fresh acknowledge with driven data retires the oldest read note
    always @(negedge i_mclk) begin
        ack_q <= ack_n;
        if (ack_q === 1'b1 && ack_n === 1'b0 && rd_oe === 1'b1) begin
            // an unexpected read must fail even when the data pins are unknown
            chk(rd, (exp_q.size() == 0) ? ((rd === 8'h00) ? 8'h01 : 8'h00) : exp_q.pop_front());
        end
    end

    // ************************************************
    // main sequence
    // ************************************************
    initial begin
        seed = 32'h7205;
        repeat (4) @(posedge i_mclk);
        i_resetn <= 1'b1;
        repeat (2) @(posedge i_mclk);
        acc(1'b1, 6'h00, 8'h00, 8'h00);
        v = 8'($random(seed)) & 8'hFB; // probe bit kept clear
        acc(1'b0, 6'h1F, v, 8'h00);
        acc(1'b1, 6'h0A, 8'h00, v);
        // random round trip in every stream of both connection pages
        for (int k = 0; k < 8; k++) begin
            v = 8'($random(seed)) & 8'h7F;
            a = {1'b1, 5'($random(seed))};
            acc(1'b0, 6'h00, {3'h0, 2'(k / 4 + 2), 1'b0, 2'(k)}, 8'h00);
            acc(1'b0, a, v, 8'h00);
            acc(1'b1, a, 8'h00, v);
        end
        acc(1'b0, 6'h00, 8'h10, 8'h00);
        acc(1'b0, 6'h21, 8'h11, 8'h00);
        acc(1'b0, 6'h00, 8'h11, 8'h00);
        acc(1'b0, 6'h21, 8'h22, 8'h00);
        acc(1'b0, 6'h00, 8'h10, 8'h00);
        acc(1'b1, 6'h21, 8'h00, 8'h11);
        acc(1'b0, 6'h00, 8'h03, 8'h00);
        acc(1'b0, 6'h3F, 8'h5A, 8'h00);
        acc(1'b1, 6'h3F, 8'h00, 8'h00);
        repeat (600) @(posedge link_clk);
        acc(1'b0, 6'h00, 8'h0A, 8'h00);
        acc(1'b1, 6'h25, 8'h00, 8'hFF);
        acc(1'b0, 6'h00, 8'h0B, 8'h00);
        acc(1'b1, 6'h25, 8'h00, 8'h00);
        acc(1'b0, 6'h00, 8'h82, 8'h00);
        acc(1'b1, 6'h33, 8'h00, 8'hFF);
        acc(1'b0, 6'h33, 8'h5A, 8'h00);
        acc(1'b0, 6'h00, 8'h12, 8'h00);
        acc(1'b1, 6'h33, 8'h00, 8'h5A);
        // frozen clock enable: the access must wait, then complete once it returns
        @(posedge i_mclk);
        ce <= 1'b0;
        fork
            acc(1'b1, 6'h00, 8'h00, 8'h12);
            begin
                repeat (20) begin
                    @(negedge i_mclk);
                    chk({7'h00, ack_n}, 8'h01);
                end
                @(posedge i_mclk);
                ce <= 1'b1;
            end
        join
        for (int s = 0; s < 4; s++) begin
            fill(8'h18 | 8'(s), 8'h01, 1'b0);
            fill(8'h10 | 8'(s), s[0] ? 8'h60 : 8'h40, 1'b1);
        end
        lanes_chk(4'hF, 4'h5, 4'hF);
        @(posedge i_mclk);
        gate <= 1'b0;
        lanes_chk(4'h0, 4'h0, 4'h0);
        @(posedge i_mclk);
        gate <= 1'b1;
        fill(8'h1A, 8'h00, 1'b0);
        lanes_chk(4'hB, 4'h1, 4'hB);
        fill(8'h13, 8'hFF, 1'b0);
        fill(8'h1B, 8'h05, 1'b0);
        lanes_chk(4'hB, 4'h9, 4'hB);
        acc(1'b0, 6'h00, 8'h40, 8'h00);
        lanes_chk(4'h8, 4'h8, 4'hF);
        chk(8'(exp_q.size()), 8'h00);
        close_out();
    end
endmodule
`default_nettype wire
